// file: conversion_result_formatter.sv
// Conversion result formatter: clamp, layout selection, buffering, result register
module conversion_result_formatter
	import result_format_pkg::*;
#(
	parameter int RAW_W = 28,
	parameter int DEPTH = FIFO_DEPTH_WORDS
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	// Settings from the third settings register
	input  wire logic [1:0]       i_format,
	input  wire logic             i_manual_input_select_mode,
	input  wire logic [3:0]       i_channel_tag,
	// Raw filter result
	input  wire logic             i_raw_valid,
	input  wire logic [RAW_W-1:0] i_raw_result,
	output logic                  o_raw_ready,
	// Formatted result stream
	output logic                  o_stream_valid,
	output logic [31:0]           o_stream_word,
	output logic                  o_stream_len32,
	input  wire logic             i_stream_ready,
	// Conversion result register view
	output logic [31:0]           o_result_register,
	output logic                  o_result_len32,
	output logic                  o_result_present
);
	localparam logic signed [RAW_W-1:0] HI24 = RAW_W'($signed({1'b0, SAT24_POS}));
	localparam logic signed [RAW_W-1:0] LO24 = RAW_W'($signed(SAT24_NEG));
	localparam logic signed [RAW_W-1:0] HI25 = RAW_W'($signed({1'b0, SAT25_POS}));
	localparam logic signed [RAW_W-1:0] LO25 = RAW_W'($signed(SAT25_NEG));

	logic signed [RAW_W-1:0] raw_s;
	logic [24:0]             sat25;
	logic [3:0]              tag_eff;
	logic [31:0]             push_word;
	logic                    push_len32;
	logic                    accept;
	logic [24:0]             value_q;
	logic [3:0]              tag_q;
	logic                    fifo_in_ready;
	logic                    fifo_out_valid;
	logic [32:0]             fifo_out_data;

	// Lay out one clamped 25-bit value in the selected format
	function automatic logic [31:0] format_word(
		input logic [24:0] v,
		input logic [1:0]  f,
		input logic [3:0]  t
	);
		logic [23:0] c24;
		logic [31:0] w;
		c24 = v[23:0];
		w   = WORD_RESET;
		if (v[24] != v[23]) begin
			c24 = v[24] ? SAT24_NEG : SAT24_POS;
		end
		case (f)
			FMT_PLAIN24:  w = {8'h00, c24};
			FMT_LEFT32:   w = {c24, 8'h00};
			FMT_RIGHT25:  w = {{7{v[24]}}, v};
			FMT_TAGGED25: w = {t, {3{v[24]}}, v};
			default:      w = WORD_RESET;
		endcase
		return w;
	endfunction : format_word

	// Extended clamp; raw codes carry 2^23 LSB per full scale
	assign raw_s = $signed(i_raw_result);
	always_comb begin
		if (raw_s > HI25) begin
			sat25 = SAT25_POS;
		end else if (raw_s < LO25) begin
			sat25 = SAT25_NEG;
		end else begin
			sat25 = i_raw_result[24:0];
		end
	end

	assign tag_eff    = i_manual_input_select_mode ? TAG_MANUAL : i_channel_tag;
	assign push_word  = format_word(sat25, i_format, tag_eff);
	assign push_len32 = (i_format != FMT_PLAIN24);
	assign accept     = i_raw_valid && fifo_in_ready;

	// Stream buffer, word plus length flag
	result_fifo #(
		.WIDTH (33),
		.DEPTH (DEPTH)
	) u_fifo (
		.i_clk       (i_clk),
		.i_reset_n   (i_reset_n),
		.i_in_valid  (i_raw_valid),
		.i_in_data   ({push_len32, push_word}),
		.o_in_ready  (fifo_in_ready),
		.o_out_valid (fifo_out_valid),
		.o_out_data  (fifo_out_data),
		.i_out_ready (i_stream_ready)
	);

	assign o_raw_ready    = fifo_in_ready;
	assign o_stream_valid = fifo_out_valid;
	assign o_stream_word  = fifo_out_data[31:0];
	assign o_stream_len32 = fifo_out_data[32];

	// Latest conversion kept until the next one
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			value_q          <= VALUE_RESET;
			tag_q            <= TAG_RESET;
			o_result_present <= 1'b0;
		end else if (accept) begin
			value_q          <= sat25;
			tag_q            <= tag_eff;
			o_result_present <= 1'b1;
		end
	end

	// Register view follows the current format
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_result_register <= WORD_RESET;
			o_result_len32    <= 1'b0;
		end else begin
			o_result_register <= format_word(value_q, i_format, tag_q);
			o_result_len32    <= (i_format != FMT_PLAIN24);
		end
	end

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	a_clamp24_pos: assert property (accept && !i_format[1] && raw_s > HI24
		|-> push_word[23:0] == SAT24_POS || push_word[31:8] == SAT24_POS)
		else $error("24-bit positive clamp wrong");

	a_clamp24_neg: assert property (accept && i_format == FMT_PLAIN24 && raw_s < LO24
		|-> push_word == {8'h00, SAT24_NEG})
		else $error("24-bit negative clamp wrong");

	a_clamp25_both: assert property (accept && i_format == FMT_RIGHT25
		|-> (raw_s > HI25 ? push_word[24:0] == SAT25_POS : 1'b1)
		&& (raw_s < LO25 ? push_word[24:0] == SAT25_NEG : 1'b1))
		else $error("25-bit clamp wrong");

	a_plain_len: assert property (accept && i_format == FMT_PLAIN24
		|-> !push_len32 && push_word[31:24] == 8'h00)
		else $error("24-bit layout not 24 bits");

	a_left_pad: assert property (accept && i_format == FMT_LEFT32
		|-> push_len32 && push_word[7:0] == 8'h00)
		else $error("left layout not zero padded");

	a_sign_fill: assert property (accept && i_format == FMT_RIGHT25
		|-> push_word[31:25] == {7{push_word[24]}})
		else $error("sign copies wrong");

	a_tag_manual: assert property (accept && i_format == FMT_TAGGED25
		|-> push_word[31:28] == (i_manual_input_select_mode ? TAG_MANUAL : i_channel_tag)
		&& push_word[27:25] == {3{push_word[24]}})
		else $error("channel tag wrong");

	a_low_agree: assert property (i_raw_valid && raw_s <= HI24 && raw_s >= LO24
		|-> sat25[23:0] == i_raw_result[23:0] && sat25[24] == sat25[23])
		else $error("25-bit low bits disagree");

	sequence s_capture;
		accept ##1 $stable(i_format) [*2];
	endsequence

	a_reg_view: assert property (s_capture |->
		o_result_len32 == (i_format != FMT_PLAIN24) && o_result_present
		&& o_result_register == format_word($past(value_q), $past(i_format), $past(tag_q)))
		else $error("result register view wrong");

	a_no_loss: assert property (!accept
		|=> $stable(value_q) && $stable(tag_q))
		else $error("result changed without accept");

	a_clamp24_lpos: assert property (accept && i_format == FMT_LEFT32 && raw_s > HI24
		|-> push_word == {SAT24_POS, 8'h00})
		else $error("left layout positive clamp wrong");

	a_clamp24_lneg: assert property (accept && i_format == FMT_LEFT32 && raw_s < LO24
		|-> push_word == {SAT24_NEG, 8'h00})
		else $error("left layout negative clamp wrong");

	a_clamp24_ppos: assert property (accept && i_format == FMT_PLAIN24 && raw_s > HI24
		|-> push_word == {8'h00, SAT24_POS})
		else $error("plain layout positive clamp wrong");

	a_clamp25_tpos: assert property (accept && i_format == FMT_TAGGED25 && raw_s > HI25
		|-> push_word[24:0] == SAT25_POS)
		else $error("tagged layout positive clamp wrong");

	a_clamp25_tneg: assert property (accept && i_format == FMT_TAGGED25 && raw_s < LO25
		|-> push_word[24:0] == SAT25_NEG)
		else $error("tagged layout negative clamp wrong");

	a_wide_value: assert property (accept && i_format[1]
		&& raw_s <= HI25 && raw_s >= LO25
		|-> push_word[24:0] == i_raw_result[24:0])
		else $error("25-bit value altered");

	a_scale_unity: assert property (accept && i_format == FMT_RIGHT25
		&& raw_s <= HI25 && raw_s >= LO25
		|-> $signed(RAW_W'(push_word)) == raw_s)
		else $error("right layout not one code per LSB");

	a_plain_value: assert property (accept && i_format == FMT_PLAIN24
		&& raw_s <= HI24 && raw_s >= LO24
		|-> push_word[23:0] == i_raw_result[23:0])
		else $error("plain layout value altered");

	a_left_value: assert property (accept && i_format == FMT_LEFT32
		&& raw_s <= HI24 && raw_s >= LO24
		|-> push_word[31:8] == i_raw_result[23:0])
		else $error("left layout value altered");

	a_tag_live: assert property (accept && i_format == FMT_TAGGED25
		&& !i_manual_input_select_mode
		|-> push_word[31:28] == i_channel_tag)
		else $error("live channel tag wrong");

	a_len_follow: assert property (accept
		|-> push_len32 == (i_format != FMT_PLAIN24))
		else $error("word length flag wrong");

	a_stream_hold: assert property (o_stream_valid && !i_stream_ready
		|=> o_stream_valid && $stable(o_stream_word) && $stable(o_stream_len32))
		else $error("stream word dropped while stalled");

	a_stream_short: assert property (o_stream_valid && !o_stream_len32
		|-> o_stream_word[31:24] == 8'h00)
		else $error("short stream word has upper byte");

	a_value_capture: assert property (accept
		|=> value_q == $past(sat25) && tag_q == $past(tag_eff))
		else $error("result not captured");

	a_view_present: assert property (accept
		|=> o_result_present)
		else $error("present flag not set");

	a_present_sticky: assert property (o_result_present
		|=> o_result_present)
		else $error("present flag lost");

	// Register view checks
	a_view_len: assert property (o_result_present
		|=> o_result_len32 == ($past(i_format) != FMT_PLAIN24))
		else $error("register view length wrong");

	a_view_short: assert property (!o_result_len32
		|-> o_result_register[31:24] == 8'h00)
		else $error("short register view has upper byte");

	a_view_pad: assert property (i_format == FMT_LEFT32
		|=> o_result_register[7:0] == 8'h00)
		else $error("register view not zero padded");

	a_view_sign: assert property (i_format == FMT_RIGHT25
		|=> o_result_register[31:25] == {7{o_result_register[24]}})
		else $error("register view sign copies wrong");

	a_view_tsign: assert property (i_format == FMT_TAGGED25
		|=> o_result_register[27:25] == {3{o_result_register[24]}})
		else $error("register view tagged sign copies wrong");

	a_view_wide: assert property (i_format[1]
		|=> o_result_register[24:0] == $past(value_q))
		else $error("register view 25-bit value wrong");

	a_view_agree: assert property (i_format == FMT_PLAIN24 && value_q[24] == value_q[23]
		|=> o_result_register[23:0] == $past(value_q[23:0]))
		else $error("register view low bits disagree");

	a_view_cpos: assert property (i_format == FMT_PLAIN24 && !value_q[24] && value_q[23]
		|=> o_result_register == {8'h00, SAT24_POS})
		else $error("register view positive clamp wrong");

	a_view_cneg: assert property (i_format == FMT_PLAIN24 && value_q[24] && !value_q[23]
		|=> o_result_register == {8'h00, SAT24_NEG})
		else $error("register view negative clamp wrong");

	a_view_lpos: assert property (i_format == FMT_LEFT32 && !value_q[24] && value_q[23]
		|=> o_result_register == {SAT24_POS, 8'h00})
		else $error("register view left positive clamp wrong");

	a_view_lneg: assert property (i_format == FMT_LEFT32 && value_q[24] && !value_q[23]
		|=> o_result_register == {SAT24_NEG, 8'h00})
		else $error("register view left negative clamp wrong");

	sequence s_manual_capture;
		accept && i_manual_input_select_mode ##1 i_format == FMT_TAGGED25;
	endsequence

	a_view_manual: assert property (s_manual_capture |=>
		o_result_register[31:28] == TAG_MANUAL)
		else $error("register view tag not forced");

	sequence s_live_capture;
		accept && !i_manual_input_select_mode ##1 i_format == FMT_TAGGED25;
	endsequence

	a_view_tag: assert property (s_live_capture |=>
		o_result_register[31:28] == $past(i_channel_tag, 2))
		else $error("register view tag wrong");

endmodule : conversion_result_formatter

// file: conversion_result_formatter_tb_top.sv
// Testbench for the conversion result formatter
module conversion_result_formatter_tb_top
	import result_format_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk = 1'b0;
	logic        reset_n = 1'b0;
	logic [1:0]  fmt = 2'h0;
	logic        manual = 1'b0;
	logic [3:0]  tag = 4'h0;
	logic        raw_valid = 1'b0;
	logic [27:0] raw = 28'h000_0000;
	logic        stall = 1'b0;
	logic        raw_ready, s_valid, s_len32, s_ready, r_len32, r_present;
	logic [31:0] s_word, r_reg;
	int          err_total = 0;
	int          total_checks = 0;
	always #12.5 clk = ~clk;
	conversion_result_formatter #(.RAW_W(28), .DEPTH(FIFO_DEPTH_WORDS)) u_conversion_result_formatter (
		.i_clk(clk), .i_reset_n(reset_n), .i_format(fmt), .i_manual_input_select_mode(manual),
		.i_channel_tag(tag), .i_raw_valid(raw_valid), .i_raw_result(raw), .o_raw_ready(raw_ready),
		.o_stream_valid(s_valid), .o_stream_word(s_word), .o_stream_len32(s_len32), .i_stream_ready(s_ready),
		.o_result_register(r_reg), .o_result_len32(r_len32), .o_result_present(r_present));
	host_reader_model u_host_reader_model (.i_clk(clk), .i_valid(s_valid), .i_word(s_word),
		.i_len32(s_len32), .o_ready(s_ready), .i_stall(stall));
	function automatic logic [31:0] expect_fmt(logic signed [27:0] r, logic [1:0] f, logic [3:0] t);
		logic [24:0] v;
		logic [23:0] c;
		v = (r > 28'sh0FF_FFFF) ? SAT25_POS : (r < -28'sh100_0000) ? SAT25_NEG : r[24:0];
		c = (r > 28'sh07F_FFFF) ? SAT24_POS : (r < -28'sh080_0000) ? SAT24_NEG : r[23:0];
		case (f)
			2'h0: return {8'h00, c};
			2'h1: return {c, 8'h00};
			2'h2: return {{7{v[24]}}, v};
			default: return {t, {3{v[24]}}, v};
		endcase
	endfunction : expect_fmt
	task automatic chk(logic [32:0] got, logic [32:0] exp, string msg);
		total_checks++;
		if (got !== exp) begin
			$display("wrong value at %0t ns: %s", $time, msg);
			err_total++;
		end
	endtask : chk
	task automatic send(logic [27:0] r, logic [1:0] f, logic [3:0] t, logic m);
		int n;
		n = 0;
		@(negedge clk);
		raw_valid = 1'b1;
		raw = r;
		fmt = f;
		tag = t;
		manual = m;
		while (raw_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk({32'h0000_0000, raw_ready}, 33'h1, "input refused");
		@(negedge clk);
		raw_valid = 1'b0;
	endtask : send
	task automatic take(logic [31:0] exp, logic len);
		int n;
		n = 0;
		while (u_host_reader_model.got.size() == 0 && n < 100) begin
			@(negedge clk);
			n++;
		end
		if (u_host_reader_model.got.size() == 0) begin
			chk(33'h0, 33'h1, "stream word missing");
		end else begin
			chk(u_host_reader_model.got.pop_front(), {len, exp}, "stream word");
		end
	endtask : take
	task automatic test_layouts();
		logic [27:0] vals[10] = '{28'h000_0000, 28'h000_0001, 28'hFFF_FFFF, 28'h07F_FFFF, 28'h080_0000,
			28'hF80_0000, 28'hF7F_FFFF, 28'h0FF_FFFF, 28'h100_0000, 28'hEFF_FFFF};
		for (int f = 0; f < 4; f++) begin
			for (int i = 0; i < 10; i++) begin
				send(vals[i], 2'(f), 4'hA, 1'b0);
				take(expect_fmt(vals[i], 2'(f), 4'hA), f != 0);
			end
		end
		$display("test layouts done");
	endtask : test_layouts
	task automatic test_manual_tag();
		send(28'h000_0005, 2'h3, 4'hF, 1'b1);
		take(expect_fmt(28'h000_0005, 2'h3, TAG_MANUAL), 1'b1);
		$display("test manual tag done");
	endtask : test_manual_tag
	task automatic test_fifo_full();
		stall = 1'b1;
		for (int i = 0; i < 5; i++) send(28'(i + 16), 2'h2, 4'h1, 1'b0);
		repeat (2) @(negedge clk);
		chk({32'h0000_0000, raw_ready}, 33'h0, "full buffer still ready");
		fork
			send(28'h000_0015, 2'h2, 4'h1, 1'b0);
			begin
				repeat (4) @(negedge clk);
				stall = 1'b0;
			end
		join
		for (int i = 0; i < 6; i++) take(expect_fmt(28'(i + 16), 2'h2, 4'h1), 1'b1);
		$display("test fifo full done");
	endtask : test_fifo_full
	task automatic test_register_view();
		send(28'hFFF_FFFE, 2'h0, 4'h6, 1'b0);
		take(expect_fmt(28'hFFF_FFFE, 2'h0, 4'h6), 1'b0);
		repeat (2) @(negedge clk);
		chk({r_len32, r_reg}, {1'b0, expect_fmt(28'hFFF_FFFE, 2'h0, 4'h6)}, "register plain");
		chk({32'h0000_0000, r_present}, 33'h1, "present flag");
		fmt = 2'h3;
		repeat (2) @(negedge clk);
		chk({r_len32, r_reg}, {1'b1, expect_fmt(28'hFFF_FFFE, 2'h3, 4'h6)}, "register reformat");
		reset_n = 1'b0;
		@(negedge clk);
		chk({r_present, r_reg}, 33'h0, "register after mid-run reset");
		reset_n = 1'b1;
		repeat (2) @(negedge clk);
		chk({32'h0000_0000, raw_ready}, 33'h1, "ready after mid-run reset");
		$display("test register view done");
	endtask : test_register_view
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : give_verdict
	initial begin
		repeat (12) @(negedge clk);
		reset_n = 1'b1;
		chk({r_present, r_reg}, 33'h0, "register after reset");
		repeat (2) @(negedge clk);
		test_layouts();
		test_manual_tag();
		test_fifo_full();
		test_register_view();
		give_verdict();
	end
	initial begin
		#125000;
		err_total++;
		give_verdict();
	end
endmodule : conversion_result_formatter_tb_top

// file: host_reader_model.sv
// Host side model that drains formatted words, with optional stalls
module host_reader_model (
	// Clock
	input  wire logic        i_clk,
	// Stream from the formatter
	input  wire logic        i_valid,
	input  wire logic [31:0] i_word,
	input  wire logic        i_len32,
	output logic             o_ready,
	// Stall request from the bench
	input  wire logic        i_stall
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [32:0] got[$];
	initial o_ready = 1'b0;
	always @(posedge i_clk) o_ready <= !i_stall;
	// Whole words kept with their length flag
	always @(posedge i_clk) if (i_valid && o_ready) got.push_back({i_len32, i_word});
endmodule : host_reader_model

// file: result_fifo.sv
// Small FIFO with registered read data and registered ready
module result_fifo #(
	parameter int WIDTH = 33,
	parameter int DEPTH = 4
) (
	// Clock and reset
	input  wire logic             i_clk,
	input  wire logic             i_reset_n,
	// Fill side
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	// Drain side
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH + 1);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [CW-1:0]    cnt_q;
	logic [CW-1:0]    cnt_d;
	logic             push;
	logic             pop;

	assign push = i_in_valid && o_in_ready;
	assign pop  = (cnt_q != '0) && (!o_out_valid || i_out_ready);

	always_comb begin
		cnt_d = cnt_q;
		if (push && !pop) begin
			cnt_d = cnt_q + CW'(1);
		end else if (pop && !push) begin
			cnt_d = cnt_q - CW'(1);
		end
	end

	// Storage
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_in_data;
		end
	end

	// Pointers and fill level
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			wr_ptr_q   <= '0;
			rd_ptr_q   <= '0;
			cnt_q      <= '0;
			o_in_ready <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + AW'(1);
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + AW'(1);
			end
			cnt_q      <= cnt_d;
			o_in_ready <= (cnt_d != CW'(DEPTH));
		end
	end

	// Registered read stage
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_out_valid <= 1'b0;
			o_out_data  <= '0;
		end else if (pop) begin
			o_out_valid <= 1'b1;
			o_out_data  <= mem_q[rd_ptr_q];
		end else if (i_out_ready) begin
			o_out_valid <= 1'b0;
		end
	end

endmodule : result_fifo

// file: result_format_pkg.sv
// Constants for the conversion result formatter
// Operation
// - A two-bit format field picks one 24-bit layout or three 32-bit layouts.
// - Full-scale input times gain maps to 8,388,608 LSB codes.
// - Upper format bit zero: 24-bit signed two's complement, MSB first, no overrange.
// - 24-bit layouts clamp at 0x7FFFFF above and 0x800000 below full scale.
// - Format 00: result register is exactly 24 bits, only the signed value.
// - Format 01: 32-bit word, 24-bit code left justified, last byte zero.
// - Upper format bit one: 25-bit signed value in a 32-bit word, double range.
// - 25-bit layouts clamp at +16777215 above and 0x1000000 below.
// - Inside normal range, lower 24 bits agree between 24-bit and 25-bit layouts.
// - Format 10: 25-bit value right justified, upper bits copy the sign bit.
// - Format 11: as 10, but the top nibble holds the channel tag.
// - Manual input select mode forces the channel tag to 0000.
// - Result register sits at address 0x0, 24 bits long by default.
package result_format_pkg;

	// Result register placement and size
	localparam logic [7:0]  RESULT_REG_ADDR   = 8'h00;
	localparam int          RESULT_LEN_SHORT  = 24;
	localparam int          RESULT_LEN_LONG   = 32;

	// Scaling and clamp codes
	localparam int          FULL_SCALE_LSB    = 8388608;
	localparam logic [23:0] SAT24_POS         = 24'h7F_FFFF;
	localparam logic [23:0] SAT24_NEG         = 24'h80_0000;
	localparam logic [24:0] SAT25_POS         = 25'h0FF_FFFF;
	localparam logic [24:0] SAT25_NEG         = 25'h100_0000;

	// Format field codes
	localparam logic [1:0]  FMT_PLAIN24       = 2'h0;
	localparam logic [1:0]  FMT_LEFT32        = 2'h1;
	localparam logic [1:0]  FMT_RIGHT25       = 2'h2;
	localparam logic [1:0]  FMT_TAGGED25      = 2'h3;
	localparam logic [3:0]  TAG_MANUAL        = 4'h0;

	// Values after reset
	localparam logic [31:0] WORD_RESET        = 32'h0000_0000;
	localparam logic [24:0] VALUE_RESET       = 25'h000_0000;
	localparam logic [3:0]  TAG_RESET         = 4'h0;

	// Buffer depth
	localparam int          FIFO_DEPTH_WORDS  = 4;

endpackage : result_format_pkg
